// ---- rtl/nv_host_pkg.sv ----
// Constants for the nonvolatile SRAM host controller.
// Assumes a 10 MHz clk; all times below are converted to cycle counts.
package nv_host_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int MEM_BYTES = 8192;
   // Times in their own units
   localparam int INITIATION_MIN_TIME_NS = 20;
   localparam int STORE_TIME_MS = 10;
   localparam int RECALL_DURATION_US = 20;
   localparam int POWERUP_RECALL_TIME_US = 550;
   localparam int ACCESS_TIME_NS = 55;
   localparam int WRITE_PULSE_NS = 45;
   localparam int WRITE_OUTPUT_OFF_DELAY_NS = 15;
   // Cycle counts: least times round up
   localparam int INIT_CYC = (INITIATION_MIN_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000 < 1 ? 1 :
      (INITIATION_MIN_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int STORE_CYC = STORE_TIME_MS * (CLK_HZ / 1000);
   localparam int RECALL_CYC = RECALL_DURATION_US * (CLK_HZ / 1_000_000);
   localparam int POWERUP_CYC = POWERUP_RECALL_TIME_US * (CLK_HZ / 1_000_000);
   localparam int ACCESS_CYC = (ACCESS_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int WPULSE_CYC = (WRITE_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int WOFF_CYC = (WRITE_OUTPUT_OFF_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int CNT_W = 24;
   // Commands
   localparam logic [1:0] CMD_READ = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_STORE = 2'h2;
   localparam logic [1:0] CMD_RECALL = 2'h3;
endpackage

// ---- rtl/nv_cycle_timer.sv ----
// Down counter used to time each bus phase.
// Assumes one clock domain shared with the controller.
`timescale 1ns/10ps
`default_nettype none
module nv_cycle_timer #(
   parameter int W = 24
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic load,
   input wire logic [W-1:0] value,
   output logic done
);
   logic [W-1:0] cnt_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (ce) begin
         if (load) begin
            cnt_q <= value;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
   assign done = (cnt_q == '0);
endmodule // nv_cycle_timer
`default_nettype wire

// ---- rtl/nv_sram_host.sv ----
// Host controller driving a nonvolatile SRAM over its parallel pins.
// Assumes the memory pins are wired directly; data_pins resolved by the bench.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Address held stable from before write start until write enable rises.
// - Output enable kept high for the whole write.
// - STORE: output enable high and write enable low first, chip select falls last.
// - STORE condition held at least 20 ns then released.
// - RECALL condition held at least 20 ns then released.
// - No access for 550 us after reset release.
// - Write enable and chip select held high during the power-up wait.
module nv_sram_host #(
   parameter int POWERUP_CYCLES = nv_host_pkg::POWERUP_CYC,
   parameter int STORE_CYCLES = nv_host_pkg::STORE_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic req_valid,
   input wire logic [1:0] req_cmd,
   input wire logic [nv_host_pkg::ADDR_W-1:0] req_addr,
   input wire logic [nv_host_pkg::DATA_W-1:0] req_wdata,
   input wire logic supply_low,
   output logic req_ready,
   output logic rsp_valid,
   output logic [nv_host_pkg::DATA_W-1:0] rsp_rdata,
   output logic rsp_refused,
   output logic chip_sel_n,
   output logic out_en_n,
   output logic write_en_n,
   output logic shadow_transfer_n,
   output logic [nv_host_pkg::ADDR_W-1:0] address_pins,
   output logic [nv_host_pkg::DATA_W-1:0] data_pins_out,
   output logic data_pins_oe,
   input wire logic [nv_host_pkg::DATA_W-1:0] data_pins_in
);
   // ------------------------------------------------------------
   // Types and state
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_POWERUP = 4'h0,
      ST_IDLE = 4'h1,
      ST_RD_SETUP = 4'h2,
      ST_RD_WAIT = 4'h3,
      ST_WR_SETUP = 4'h4,
      ST_WR_PULSE = 4'h5,
      ST_WR_END = 4'h6,
      ST_XF_SETUP = 4'h7,
      ST_XF_INIT = 4'h8,
      ST_XF_WAIT = 4'h9,
      ST_DONE = 4'hA,
      ST_XF_ARM = 4'hB
   } state_e;

   localparam int CW = nv_host_pkg::CNT_W;

   state_e state_q;
   logic is_store_q;
   logic [nv_host_pkg::DATA_W-1:0] rd_sync1_q;
   logic [nv_host_pkg::DATA_W-1:0] rd_sync2_q;
   logic [1:0] sup_sync_q;
   logic t_load;
   logic [CW-1:0] t_value;
   logic t_done;
   logic pu_loaded_q;

   function automatic logic [CW-1:0] cyc(input int n);
      cyc = CW'(n < 1 ? 1 : n);
   endfunction

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_sync1_q <= '0;
         rd_sync2_q <= '0;
         sup_sync_q <= 2'h3;
      end else if (ce) begin
         rd_sync1_q <= data_pins_in;
         rd_sync2_q <= rd_sync1_q;
         sup_sync_q <= {sup_sync_q[0], supply_low};
      end
   end

   // ------------------------------------------------------------
   // Phase timer
   // ------------------------------------------------------------
   nv_cycle_timer #(.W(CW)) u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .load(t_load),
      .value(t_value),
      .done(t_done)
   );

   always_comb begin
      t_load = 1'b0;
      t_value = '0;
      if (state_q == ST_POWERUP) begin
         if (!pu_loaded_q) begin
            t_load = 1'b1;
            t_value = cyc(POWERUP_CYCLES);
         end
      end else begin
         case (state_q)
            ST_RD_SETUP: begin
               t_load = 1'b1;
               t_value = cyc(nv_host_pkg::ACCESS_CYC + 2);
            end
            ST_WR_SETUP: begin
               t_load = 1'b1;
               t_value = cyc(nv_host_pkg::WPULSE_CYC);
            end
            ST_XF_ARM: begin
               t_load = 1'b1;
               t_value = cyc(nv_host_pkg::INIT_CYC);
            end
            ST_XF_INIT: begin
               if (t_done) begin
                  t_load = 1'b1;
                  t_value = is_store_q ? cyc(STORE_CYCLES)
                     : cyc(nv_host_pkg::RECALL_CYC);
               end
            end
            default: t_load = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pu_loaded_q <= 1'b0;
      end else if (ce) begin
         pu_loaded_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= ST_POWERUP;
         is_store_q <= 1'b0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_refused <= 1'b0;
         rsp_rdata <= '0;
         chip_sel_n <= 1'b1;
         out_en_n <= 1'b1;
         write_en_n <= 1'b1;
         shadow_transfer_n <= 1'b1;
         address_pins <= '0;
         data_pins_out <= '0;
         data_pins_oe <= 1'b0;
      end else if (ce) begin
         rsp_valid <= 1'b0;
         rsp_refused <= 1'b0;
         case (state_q)
            ST_POWERUP: begin
               if (pu_loaded_q && t_done) begin
                  state_q <= ST_IDLE;
                  req_ready <= 1'b1;
               end
            end
            ST_IDLE: begin
               chip_sel_n <= 1'b1;
               out_en_n <= 1'b1;
               write_en_n <= 1'b1;
               shadow_transfer_n <= 1'b1;
               data_pins_oe <= 1'b0;
               if (req_valid) begin
                  req_ready <= 1'b0;
                  address_pins <= req_addr;
                  data_pins_out <= req_wdata;
                  case (req_cmd)
                     nv_host_pkg::CMD_READ: state_q <= ST_RD_SETUP;
                     nv_host_pkg::CMD_WRITE: state_q <= ST_WR_SETUP;
                     nv_host_pkg::CMD_STORE: begin
                        if (sup_sync_q[1]) begin
                           rsp_valid <= 1'b1;
                           rsp_refused <= 1'b1;
                           state_q <= ST_DONE;
                        end else begin
                           is_store_q <= 1'b1;
                           state_q <= ST_XF_SETUP;
                        end
                     end
                     default: begin
                        is_store_q <= 1'b0;
                        state_q <= ST_XF_SETUP;
                     end
                  endcase
               end
            end
            ST_RD_SETUP: begin
               chip_sel_n <= 1'b0;
               out_en_n <= 1'b0;
               state_q <= ST_RD_WAIT;
            end
            ST_RD_WAIT: begin
               if (t_done) begin
                  rsp_rdata <= rd_sync2_q;
                  rsp_valid <= 1'b1;
                  chip_sel_n <= 1'b1;
                  out_en_n <= 1'b1;
                  state_q <= ST_DONE;
               end
            end
            ST_WR_SETUP: begin
               out_en_n <= 1'b1;
               data_pins_oe <= 1'b1;
               chip_sel_n <= 1'b0;
               write_en_n <= 1'b0;
               state_q <= ST_WR_PULSE;
            end
            ST_WR_PULSE: begin
               if (t_done) begin
                  write_en_n <= 1'b1;
                  state_q <= ST_WR_END;
               end
            end
            ST_WR_END: begin
               chip_sel_n <= 1'b1;
               data_pins_oe <= 1'b0;
               rsp_valid <= 1'b1;
               state_q <= ST_DONE;
            end
            ST_XF_SETUP: begin
               // Level pins first with chip select still high
               shadow_transfer_n <= 1'b0;
               out_en_n <= is_store_q;
               write_en_n <= !is_store_q;
               state_q <= ST_XF_ARM;
            end
            ST_XF_ARM: begin
               // Chip select falls last, giving the one fresh transition
               chip_sel_n <= 1'b0;
               state_q <= ST_XF_INIT;
            end
            ST_XF_INIT: begin
               if (t_done) begin
                  chip_sel_n <= 1'b1;
                  write_en_n <= 1'b1;
                  out_en_n <= 1'b1;
                  shadow_transfer_n <= 1'b1;
                  state_q <= ST_XF_WAIT;
               end
            end
            ST_XF_WAIT: begin
               data_pins_oe <= 1'b0;
               if (t_done) begin
                  rsp_valid <= 1'b1;
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               req_ready <= 1'b1;
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

endmodule // nv_sram_host
`default_nettype wire

// ---- testbench/nv_sram_host_monitor.sv ----
// Pin-level checker for the nonvolatile SRAM host controller.
// Assumes it is bound into nv_sram_host; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module nv_sram_host_monitor #(
   parameter int POWERUP_CYCLES = 1,
   parameter int STORE_CYCLES = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic rsp_refused,
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic write_en_n,
   input wire logic shadow_transfer_n,
   input wire logic [12:0] address_pins,
   input wire logic data_pins_oe
);
   // ----------------
   // Pin properties
   // ----------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [15:0] up_q;
   always_ff @(posedge clk) begin
      if (!rst_n) up_q <= 16'h0;
      else if (up_q != 16'hFFFF) up_q <= up_q + 16'h1;
   end
   sequence s_store;
      !shadow_transfer_n && !chip_sel_n && !write_en_n;
   endsequence
   sequence s_recall;
      !shadow_transfer_n && !chip_sel_n && !out_en_n && write_en_n;
   endsequence
   property p_powerup;
      up_q < POWERUP_CYCLES - 1 |-> !req_ready && write_en_n;
   endproperty
   property p_store_wait;
      s_store ##1 shadow_transfer_n |-> !rsp_valid [*8];
   endproperty
   property p_recall_wait;
      s_recall ##1 shadow_transfer_n |-> !rsp_valid [*8];
   endproperty
   property p_we_oe;
      !write_en_n |-> out_en_n;
   endproperty
   property p_recall_we;
      !out_en_n && !shadow_transfer_n |-> write_en_n;
   endproperty
   property p_addr;
      !write_en_n && !chip_sel_n && shadow_transfer_n |-> $stable(address_pins);
   endproperty
   property p_drive;
      data_pins_oe |-> out_en_n && shadow_transfer_n;
   endproperty
   property p_write;
      $fell(write_en_n) && shadow_transfer_n |-> !chip_sel_n && data_pins_oe ##1 !chip_sel_n;
   endproperty
   property p_read;
      !out_en_n && shadow_transfer_n |-> write_en_n && !data_pins_oe;
   endproperty
   property p_cs_last;
      $fell(chip_sel_n) && !shadow_transfer_n |-> !$past(shadow_transfer_n) && $stable(out_en_n)
         && $stable(write_en_n);
   endproperty
   property p_refused;
      rsp_refused |-> rsp_valid && shadow_transfer_n && $past(shadow_transfer_n);
   endproperty
   a_powerup: assert property (p_powerup) else $error("early access");
   a_store_wait: assert property (p_store_wait) else $error("store end early");
   a_recall_wait: assert property (p_recall_wait) else $error("recall end early");
   a_we_oe: assert property (p_we_oe) else $error("oe low with we");
   a_recall_we: assert property (p_recall_we) else $error("we low in recall");
   a_addr: assert property (p_addr) else $error("address moved");
   a_drive: assert property (p_drive) else $error("bus contention");
   a_write: assert property (p_write) else $error("bad write");
   a_read: assert property (p_read) else $error("bad read");
   a_refused: assert property (p_refused) else $error("bad refusal");
   a_cs_last: assert property (p_cs_last) else $error("chip select not last");
endmodule // nv_sram_host_monitor
bind nv_sram_host nv_sram_host_monitor #(
   .POWERUP_CYCLES(POWERUP_CYCLES),
   .STORE_CYCLES(STORE_CYCLES)
) nv_sram_host_monitor_inst (.clk, .rst_n, .req_ready, .rsp_valid, .rsp_refused,
   .chip_sel_n, .out_en_n, .write_en_n, .shadow_transfer_n, .address_pins, .data_pins_oe);
`default_nettype wire

// ---- testbench/nv_device_model.sv ----
// Behavioural model of the nonvolatile SRAM.
// Assumes the bench resolves the shared data bus.
`timescale 1ns/10ps
`default_nettype none
module nv_device_model #(
   parameter int T_PWR = 1500,
   parameter int T_STORE = 600,
   parameter int T_RECALL = 5000
) (
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic write_en_n,
   input wire logic shadow_transfer_n,
   input wire logic supply_low,
   input wire logic [12:0] address_pins,
   input wire logic [7:0] data_pins,
   output logic [7:0] dev_out,
   output logic dev_oe
);
   // -------------
   // Array model
   // -------------
   logic [7:0] sram [8192];
   logic [7:0] nv [8192];
   logic busy = 1'b1;
   wire logic wr_on = !chip_sel_n && !write_en_n && shadow_transfer_n;
   wire logic st = !chip_sel_n && !write_en_n && out_en_n && !shadow_transfer_n;
   wire logic rc = !chip_sel_n && write_en_n && !out_en_n && !shadow_transfer_n;
   assign dev_oe = !busy && !chip_sel_n && !out_en_n && write_en_n && shadow_transfer_n;
   assign dev_out = sram[address_pins];
   initial begin
      foreach (nv[i]) nv[i] = 8'h00;
      sram = nv;
      #(T_PWR) busy = 1'b0;
   end
   always @(negedge wr_on) begin
      if (!busy) sram[address_pins] = data_pins;
   end
   always @(posedge st) begin
      if (!busy && !supply_low) begin
         busy = 1'b1;
         foreach (nv[i]) nv[i] = 8'hFF;
         nv = sram;
         #(T_STORE) busy = 1'b0;
      end
   end
   always @(posedge rc) begin
      if (!busy) begin
         busy = 1'b1;
         foreach (sram[i]) sram[i] = 8'h00;
         sram = nv;
         #(T_RECALL) busy = 1'b0;
      end
   end
endmodule // nv_device_model
`default_nettype wire

// ---- testbench/nv_sram_host_tb.sv ----
// Self-checking bench for nv_sram_host with a device model.
// Assumes nv_host_pkg, the model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module nv_sram_host_tb;
   // ----------
   // Harness
   // ----------
   localparam int PWR = 20;
   logic clk, rst_n, req_valid, supply_low, req_ready, rsp_valid, rsp_refused, rf, early;
   logic chip_sel_n, out_en_n, write_en_n, shadow_transfer_n, data_pins_oe, dev_oe;
   logic ce, ce_mix;
   logic [1:0] req_cmd;
   logic [12:0] req_addr, address_pins, a;
   logic [7:0] req_wdata, rsp_rdata, data_pins_out, dev_out, rd, last_q = 8'h5A;
   logic [31:0] r;
   wire logic [7:0] bus;
   int n_errors = 0;
   int n_tests = 0;
   int seed = 32'hd5a6;
   logic [7:0] mem_m [8192];
   logic [7:0] nv_m [8192];
   logic [12:0] aq [$];
   assign bus = data_pins_oe ? (dev_oe ? 8'hXX : data_pins_out) : (dev_oe ? dev_out : ~last_q);
   always @(posedge clk) last_q <= bus;
   always @(posedge clk) begin
      #10;
      ce = !ce_mix || ($random(seed) % 3 != 0);
   end
   nv_sram_host #(.POWERUP_CYCLES(PWR), .STORE_CYCLES(10)) nv_sram_host_inst (.clk, .rst_n,
      .ce, .req_valid, .req_cmd, .req_addr, .req_wdata, .supply_low, .req_ready,
      .rsp_valid, .rsp_rdata, .rsp_refused, .chip_sel_n, .out_en_n, .write_en_n,
      .shadow_transfer_n, .address_pins, .data_pins_out, .data_pins_oe, .data_pins_in(bus));
   nv_device_model nv_device_model_inst (.chip_sel_n, .out_en_n, .write_en_n,
      .shadow_transfer_n, .supply_low, .address_pins, .data_pins(bus), .dev_out, .dev_oe);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk({7'h0, got}, {7'h0, exp});
   endtask
   task automatic op(input logic [1:0] c, input logic [12:0] ad, input logic [7:0] d);
      int k;
      k = 0;
      while (req_ready !== 1'b1 && k < 3000) begin
         @(posedge clk);
         #10;
         k++;
      end
      req_valid = 1'b1;
      req_cmd = c;
      req_addr = ad;
      req_wdata = d;
      @(posedge clk);
      #10;
      while (req_ready === 1'b1 && k < 3000) begin
         @(posedge clk);
         #10;
         k++;
      end
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && k < 3000) begin
         @(posedge clk);
         #10;
         k++;
      end
      if (k >= 3000) n_errors++;
      rd = rsp_rdata;
      rf = rsp_refused;
   endtask
   task automatic stop_test;
      if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #1000000;
      n_errors++;
      stop_test;
   end
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_cmd = 2'h0;
      req_addr = 13'h0;
      req_wdata = 8'h00;
      supply_low = 1'b0;
      early = 1'b0;
      ce = 1'b1;
      ce_mix = 1'b0;
      foreach (mem_m[i]) mem_m[i] = 8'h00;
      repeat (2) @(posedge clk);
      #10;
      rst_n = 1'b1;
      repeat (PWR) begin
         @(posedge clk);
         #10;
         early = early | req_ready;
      end
      chk_flag(early, 1'b0);
      ce_mix = 1'b1;
      for (int i = 0; i < 16; i++) begin
         r = $random(seed);
         a = (i == 0) ? 13'h0 : (i == 1) ? 13'h1FFF : r[12:0];
         op(nv_host_pkg::CMD_WRITE, a, r[20:13]);
         mem_m[a] = r[20:13];
         aq.push_back(a);
         op(nv_host_pkg::CMD_READ, a, 8'h00);
         chk(rd, mem_m[a]);
         op(nv_host_pkg::CMD_READ, a ^ 13'h1, 8'h00);
         chk(rd, mem_m[a ^ 13'h1]);
      end
      ce_mix = 1'b0;
      op(nv_host_pkg::CMD_STORE, 13'h0, 8'h00);
      chk_flag(rf, 1'b0);
      nv_m = mem_m;
      foreach (aq[i]) op(nv_host_pkg::CMD_WRITE, aq[i], ~mem_m[aq[i]]);
      supply_low = 1'b1;
      repeat (3) @(posedge clk);
      #10;
      op(nv_host_pkg::CMD_STORE, 13'h0, 8'h00);
      chk_flag(rf, 1'b1);
      supply_low = 1'b0;
      repeat (3) @(posedge clk);
      #10;
      repeat (2) op(nv_host_pkg::CMD_RECALL, 13'h0, 8'h00);
      foreach (aq[i]) begin
         op(nv_host_pkg::CMD_READ, aq[i], 8'h00);
         chk(rd, nv_m[aq[i]]);
      end
      stop_test;
   end
endmodule // nv_sram_host_tb
`default_nettype wire
